// File: design/spi_unit_pkg.sv
// package: register map, field positions and constants of the spi unit
package spi_unit_pkg;
  // ********************
  // register byte addresses
  // ********************
  localparam logic [5:0] ADDR_RECEIVE_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_BAUD_DIVISOR_LOW = 6'h04;
  localparam logic [5:0] ADDR_BAUD_DIVISOR_HIGH = 6'h08;
  localparam logic [5:0] ADDR_MODULATION_CONTROL = 6'h0C;
  localparam logic [5:0] ADDR_RECEIVE_BUFFER = 6'h10;
  localparam logic [5:0] ADDR_TRANSMIT_BUFFER = 6'h14;
  localparam logic [5:0] ADDR_MODULE_ENABLE_TWO = 6'h18;
  localparam logic [5:0] ADDR_INTERRUPT_ENABLE_ONE = 6'h1C;
  // unit control (own register): software reset, char length, pin mode
  localparam logic [5:0] ADDR_UNIT_CONTROL = 6'h20;
  // interrupt flag register (status, write one to clear)
  localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h24;
  // ********************
  // field positions
  // ********************
  localparam int BIT_BUS_CONFLICT = 7;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_SPI_EN_UNIT1 = 4;
  localparam int BIT_SPI_EN_UNIT0 = 0;
  localparam int BIT_TX_IRQ_EN = 7;
  localparam int BIT_RX_IRQ_EN = 6;
  localparam int BIT_TX_FLAG = 7;
  localparam int BIT_RX_FLAG = 6;
  localparam int BIT_SW_RESET = 0;
  localparam int BIT_SS_CONTROL = 1;
  localparam int BIT_CHAR_8BIT = 4;
  // ********************
  // reset values and limits
  // ********************
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_UNIT_CONTROL = 8'h01;
  localparam logic [15:0] DIVISOR_MIN = 16'h0002;
  localparam logic [3:0] BITS_PER_CHAR = 4'h8;
  localparam logic [3:0] BITS_PER_SHORT_CHAR = 4'h7;
endpackage

// File: design/spi_bit_shifter.sv
// msb-first shift engine driven by a sampled link clock
`timescale 1ns/1ps
module spi_bit_shifter
  import spi_unit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic active_i,
  input wire logic sclk_rise_i,
  input wire logic sclk_fall_i,
  input wire logic mosi_i,
  input wire logic load_i,
  input wire logic [7:0] load_data_i,
  input wire logic seven_bit_i,
  output logic miso_o,
  output logic char_done_o,
  output logic [7:0] char_data_o
);
  // ********************
  // state
  // ********************
  typedef struct packed {
    logic [7:0] shift;   // shift register
    logic [3:0] count;   // bits received
    logic done;          // one-cycle completion
    logic [7:0] rx;      // completed character
  } shifter_t;
  shifter_t cur_ff;
  shifter_t nxt_cur;
  logic [3:0] last_bit;  // count of the final bit of a character

  // seven-bit frames end one bit earlier
  assign last_bit = (seven_bit_i ? BITS_PER_SHORT_CHAR : BITS_PER_CHAR)
                    - 4'h1;

  // next state
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    if (!active_i)
    begin
      nxt_cur.count = 4'h0;
    end
    if (load_i)
    begin
      nxt_cur.shift = load_data_i;
    end
    else if (active_i && sclk_rise_i)
    begin
      // sample on rising edge, shift msb first
      nxt_cur.shift = {cur_ff.shift[6:0], mosi_i};
      if (cur_ff.count == last_bit)
      begin
        nxt_cur.count = 4'h0;
        nxt_cur.done = 1'b1;
        nxt_cur.rx = {cur_ff.shift[6:0], mosi_i};
      end
      else
      begin
        nxt_cur.count = cur_ff.count + 4'h1;
      end
    end
    if (sclk_fall_i)
    begin
      nxt_cur.shift = nxt_cur.shift; // falling edge changes nothing; data moves on the rising edge
    end
  end

  // register state
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      cur_ff <= '0;
    end
    else if (clk_en_i)
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign miso_o = cur_ff.shift[7];
  assign char_done_o = cur_ff.done;
  assign char_data_o = cur_ff.rx;
endmodule

// File: design/spi_unit.sv
// spi unit: wishbone registers, flags, interrupts and link sampling
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module spi_unit
  import spi_unit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic spi_clk_i,
  input wire logic spi_mosi_i,
  input wire logic slave_select_pin_n_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic [15:0] baud_divisor_o,
  output logic divisor_valid_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic irq_o
);
  // ********************
  // state
  // ********************
  typedef struct packed {
    logic [2:0] clk_sync;     // link clock synchroniser + history
    logic [1:0] mosi_sync;    // data synchroniser
    logic [2:0] ss_sync;      // slave select synchroniser + history
    logic bus_conflict_flag;  // sticky conflict
    logic overrun_flag;       // sticky overrun
    logic rx_unread;          // buffer holds unread char
    logic [7:0] receive_buffer;
    logic [7:0] transmit_buffer;
    logic tx_full;            // transmit buffer waiting
    logic tx_load;            // load pulse to shifter
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] modulation_control;
    logic [7:0] module_enable_two;
    logic [7:0] interrupt_enable_one;
    logic [7:0] unit_control;
    logic receive_irq_flag;
    logic transmit_irq_flag;
    logic ack;
    logic [31:0] rdata;
  } regs_t;
  regs_t cur_ff;
  regs_t nxt_cur;

  logic sclk_rise;          // sampled link clock edges
  logic sclk_fall;
  logic ss_fall;            // slave select falling edge
  logic four_pin;           // slave select honoured
  logic unit_on;            // spi enabled and not in reset
  logic selected;           // shifting allowed
  logic char_done;          // character complete pulse
  logic [7:0] char_data;    // completed character
  logic shift_out;          // shifter msb
  logic wb_req;             // new bus request
  logic wr_req;             // write request
  logic rd_req;             // read request
  logic sw_reset;           // software reset bit
  logic [7:0] rx_view;      // buffer as software sees it
  logic [7:0] flags_view;   // irq flag register view
  logic tx_write;           // transmit buffer write taken
  logic rx_read;            // receive buffer read taken
  logic load_ok;            // buffer may move to shifter
  logic seven_bit;          // seven-bit characters selected

  // ********************
  // link decode
  // ********************
  // edges from second flop against the history flop
  assign sclk_rise = cur_ff.clk_sync[1] && !cur_ff.clk_sync[2];
  assign sclk_fall = !cur_ff.clk_sync[1] && cur_ff.clk_sync[2];
  assign ss_fall = !cur_ff.ss_sync[1] && cur_ff.ss_sync[2];
  assign sw_reset = cur_ff.unit_control[BIT_SW_RESET];
  assign four_pin = !cur_ff.unit_control[BIT_SS_CONTROL];
  assign unit_on = cur_ff.module_enable_two[BIT_SPI_EN_UNIT0]
                   && !sw_reset;
  // 3-pin mode ignores slave select
  assign selected = unit_on && (!four_pin || !cur_ff.ss_sync[1]);
  assign wb_req = wb_cyc_i && wb_stb_i && !cur_ff.ack;
  assign wr_req = wb_req && wb_we_i && wb_sel_i[0];
  assign rd_req = wb_req && !wb_we_i;
  // seven-bit mode: msb forced to zero
  assign rx_view = seven_bit
                   ? {1'b0, cur_ff.receive_buffer[6:0]}
                   : cur_ff.receive_buffer;
  assign flags_view = {cur_ff.transmit_irq_flag, cur_ff.receive_irq_flag,
                       6'h00};

  // ********************
  // request decode
  // ********************
  // char length bit low selects seven-bit frames
  assign seven_bit = !cur_ff.unit_control[BIT_CHAR_8BIT];
  assign tx_write = wr_req && wb_adr_i == ADDR_TRANSMIT_BUFFER;
  assign rx_read = rd_req && wb_adr_i == ADDR_RECEIVE_BUFFER;
  // move between characters, or at any time in 3-pin mode; a write landing in the same cycle
  // would otherwise be overwritten before it is sent
  assign load_ok = cur_ff.tx_full && !cur_ff.tx_load && unit_on
                   && !tx_write
                   && (cur_ff.ss_sync[1] || !four_pin || char_done);

  // ********************
  // shift engine
  // ********************
  spi_bit_shifter spi_bit_shifter_inst (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .active_i(selected),
    .sclk_rise_i(sclk_rise),
    .sclk_fall_i(sclk_fall),
    .mosi_i(cur_ff.mosi_sync[1]),
    .load_i(cur_ff.tx_load),
    .load_data_i(cur_ff.transmit_buffer),
    .seven_bit_i(seven_bit),
    .miso_o(shift_out),
    .char_done_o(char_done),
    .char_data_o(char_data)
  );

  // next state
  always_comb
  begin
    nxt_cur = cur_ff;
    // pins pass two flops before any logic reads them
    nxt_cur.clk_sync = {cur_ff.clk_sync[1:0], spi_clk_i};
    nxt_cur.mosi_sync = {cur_ff.mosi_sync[0], spi_mosi_i};
    nxt_cur.ss_sync = {cur_ff.ss_sync[1:0], slave_select_pin_n_i};
    // ack answers a taken request in the next cycle
    nxt_cur.ack = wb_req;
    // load to the shifter is a one-cycle pulse
    nxt_cur.tx_load = 1'b0;
    // bus read mux
    if (rd_req)
    begin
      unique case (wb_adr_i)
        ADDR_RECEIVE_CONTROL: nxt_cur.rdata = {24'h0,
          cur_ff.bus_conflict_flag, 1'b0, cur_ff.overrun_flag, 5'h00};
        ADDR_BAUD_DIVISOR_LOW: nxt_cur.rdata = {24'h0,
          cur_ff.baud_divisor_low};
        ADDR_BAUD_DIVISOR_HIGH: nxt_cur.rdata = {24'h0,
          cur_ff.baud_divisor_high};
        ADDR_MODULATION_CONTROL: nxt_cur.rdata = {24'h0,
          cur_ff.modulation_control};
        ADDR_RECEIVE_BUFFER: nxt_cur.rdata = {24'h0, rx_view};
        ADDR_TRANSMIT_BUFFER: nxt_cur.rdata = {24'h0,
          cur_ff.transmit_buffer};
        ADDR_MODULE_ENABLE_TWO: nxt_cur.rdata = {24'h0,
          cur_ff.module_enable_two};
        ADDR_INTERRUPT_ENABLE_ONE: nxt_cur.rdata = {24'h0,
          cur_ff.interrupt_enable_one};
        ADDR_UNIT_CONTROL: nxt_cur.rdata = {24'h0, cur_ff.unit_control};
        ADDR_IRQ_FLAGS: nxt_cur.rdata = {24'h0, flags_view};
        default: nxt_cur.rdata = 32'h0000_0000;
      endcase
    end
    // buffer read clears overrun and receive flag
    if (rx_read)
    begin
      nxt_cur.overrun_flag = 1'b0;
      nxt_cur.receive_irq_flag = 1'b0;
      nxt_cur.rx_unread = 1'b0;
    end
    // register writes
    if (wr_req)
    begin
      unique case (wb_adr_i)
        // sticky flags: software may set or clear
        ADDR_RECEIVE_CONTROL:
        begin
          nxt_cur.bus_conflict_flag = wb_dat_i[BIT_BUS_CONFLICT];
          nxt_cur.overrun_flag = wb_dat_i[BIT_OVERRUN];
        end
        ADDR_BAUD_DIVISOR_LOW: nxt_cur.baud_divisor_low = wb_dat_i[7:0];
        ADDR_BAUD_DIVISOR_HIGH: nxt_cur.baud_divisor_high = wb_dat_i[7:0];
        ADDR_MODULATION_CONTROL: nxt_cur.modulation_control = wb_dat_i[7:0];
        // new character: buffer no longer empty
        ADDR_TRANSMIT_BUFFER:
        begin
          nxt_cur.transmit_buffer = wb_dat_i[7:0];
          nxt_cur.transmit_irq_flag = 1'b0;
          nxt_cur.tx_full = 1'b1;
        end
        ADDR_MODULE_ENABLE_TWO: nxt_cur.module_enable_two = wb_dat_i[7:0];
        ADDR_INTERRUPT_ENABLE_ONE:
          nxt_cur.interrupt_enable_one = wb_dat_i[7:0];
        // software reset, pin mode and char length
        ADDR_UNIT_CONTROL: nxt_cur.unit_control = wb_dat_i[7:0];
        ADDR_IRQ_FLAGS:
        begin
          // write one to clear
          if (wb_dat_i[BIT_TX_FLAG])
            nxt_cur.transmit_irq_flag = 1'b0;
          if (wb_dat_i[BIT_RX_FLAG])
            nxt_cur.receive_irq_flag = 1'b0;
        end
        // unmapped write: ignored
        default: nxt_cur.rdata = cur_ff.rdata;
      endcase
    end
    // transmit buffer moves to shifter when no character is in flight, or at once in 3-pin mode
    if (load_ok)
    begin
      nxt_cur.tx_full = 1'b0;
      nxt_cur.tx_load = 1'b1;
    end
    // buffer empty: transmit flag set, hardware set wins
    if (!nxt_cur.tx_full && nxt_cur.tx_load)
    begin
      nxt_cur.transmit_irq_flag = 1'b1;
    end
    // character complete
    if (char_done)
    begin
      // previous character still unread
      if (cur_ff.rx_unread)
      begin
        nxt_cur.overrun_flag = 1'b1;
      end
      nxt_cur.receive_buffer = char_data;
      nxt_cur.rx_unread = 1'b1;
      nxt_cur.receive_irq_flag = 1'b1;
    end
    // slave select falls in four-pin mode
    if (ss_fall && four_pin && unit_on)
    begin
      nxt_cur.bus_conflict_flag = 1'b1;
    end
    // software reset holds overrun clear
    if (sw_reset)
    begin
      nxt_cur.overrun_flag = 1'b0;
      nxt_cur.rx_unread = 1'b0;
      nxt_cur.tx_full = 1'b0;
      nxt_cur.transmit_irq_flag = 1'b1;
    end
  end

  // register state
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      // everything not named below clears
      cur_ff <= '0;
      // idle levels: link clock low, select high, no false edge
      cur_ff.clk_sync <= 3'h0;
      cur_ff.ss_sync <= 3'h7;
      cur_ff.unit_control <= RESET_UNIT_CONTROL;
      cur_ff.transmit_irq_flag <= 1'b1;
      cur_ff.module_enable_two <= RESET_ZERO;
      cur_ff.interrupt_enable_one <= RESET_ZERO;
    end
    else if (clk_en_i)
    begin
      cur_ff <= nxt_cur;
    end
  end

  // ********************
  // outputs
  // ********************
  // bus answer
  assign wb_ack_o = cur_ff.ack;
  assign wb_dat_o = cur_ff.rdata;
  // link pins
  assign spi_miso_o = shift_out;
  assign spi_miso_oe_o = selected;
  // combined divisor and its legality
  assign baud_divisor_o = {cur_ff.baud_divisor_high,
                           cur_ff.baud_divisor_low};
  assign divisor_valid_o = baud_divisor_o >= DIVISOR_MIN;
  // interrupt requests: flag and enable
  assign tx_irq_o = cur_ff.transmit_irq_flag
                    && cur_ff.interrupt_enable_one[BIT_TX_IRQ_EN];
  assign rx_irq_o = cur_ff.receive_irq_flag
                    && cur_ff.interrupt_enable_one[BIT_RX_IRQ_EN];
  assign irq_o = tx_irq_o || rx_irq_o;
endmodule

// File: testbench/spi_unit_chk.sv
// checker: bus, divisor and interrupt relations at the spi unit ports
`timescale 1ns/1ps
module spi_unit_chk
  import spi_unit_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [15:0] baud_divisor_o,
  input wire logic divisor_valid_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic irq_o
);
  // ********************
  // one clock domain, one reset
  // ********************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // taken request is answered one cycle later
  property p_ack_next;
    clk_en_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack late");
  // ack is a single-cycle pulse
  property p_ack_once;
    wb_ack_o && clk_en_i |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack held");
  // upper read bytes and reads of unmapped address 6'h1E are zero
  property p_dat_hi;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0 &&
      (wb_we_i || wb_adr_i != 6'h1E || wb_dat_o == 32'h0);
  endproperty
  a_dat_hi: assert property (p_dat_hi)
    else $error("read data upper bits");
  // valid flag follows the combined divisor
  property p_div_ok;
    divisor_valid_o == (baud_divisor_o >= DIVISOR_MIN);
  endproperty
  a_div_ok: assert property (p_div_ok)
    else $error("divisor valid wrong");
  // buffer read drops the receive request
  property p_rd_clr;
    wb_ack_o && !wb_we_i && wb_adr_i == ADDR_RECEIVE_BUFFER |=> !rx_irq_o;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("receive request after read");
  // clearing both enables masks all requests
  property p_mask;
    wb_ack_o && wb_we_i && wb_sel_i[0] && wb_dat_i[7:6] == 2'b00 &&
      wb_adr_i == ADDR_INTERRUPT_ENABLE_ONE |=> !irq_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("request while masked");
  // combined line is the or of both requests
  property p_irq_or;
    irq_o == (tx_irq_o || rx_irq_o);
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("irq not or of requests");
  // enables are clear out of reset
  property p_rst_irq;
    $rose(reset_n_i) |-> !irq_o;
  endproperty
  a_rst_irq: assert property (p_rst_irq)
    else $error("request after reset");
endmodule
bind spi_unit spi_unit_chk chk_inst (.core_clk_i, .reset_n_i, .clk_en_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .baud_divisor_o, .divisor_valid_o, .tx_irq_o, .rx_irq_o,
  .irq_o);

// File: testbench/spi_master_model.sv
// partner: spi master driving link clock, data and select
`timescale 1ns/1ps
module spi_master_model
(
  output logic sclk_o,
  output logic mosi_o,
  output logic ss_n_o,
  input wire logic miso_i
);
  // ********************
  // idle levels: clock still, select high
  // ********************
  initial
  begin
    sclk_o = 1'b0;
    mosi_o = 1'b1;
    ss_n_o = 1'b1;
  end
  // frame of n bits, msb first, 64 ns period
  task automatic xfer(input logic [7:0] tx, input int n,
    output logic [7:0] rx);
    rx = 8'h00;
    #3 ss_n_o = 1'b0;
    for (int i = 7; i > 7 - n; i--)
    begin
      #32 sclk_o = 1'b0;
      mosi_o = tx[i];
      #32 rx[i] = miso_i;
      sclk_o = 1'b1;
    end
    #32 sclk_o = 1'b0;
    mosi_o = ~mosi_o; // released line shows no stale bit
    #64 ss_n_o = 1'b1;
  endtask
endmodule

// File: testbench/usart_spi_status_buffers_bench.sv
// bench: register, interrupt and link scenarios of the spi unit
`timescale 1ns/1ps
module usart_spi_status_buffers_bench
  import spi_unit_pkg::*;
;
  // ********************
  // design pins
  // ********************
  logic core_clk_i = 1'b0, reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic clk_en_i = 1'b1;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, spi_clk_i, spi_mosi_i, slave_select_pin_n_i;
  logic spi_miso_o, spi_miso_oe_o, divisor_valid_o;
  logic tx_irq_o, rx_irq_o, irq_o, miso_w, miso_q = 1'b0;
  logic [15:0] baud_divisor_o;
  int err_total = 0, comparisons = 0;
  always #4 core_clk_i = ~core_clk_i;
  // released miso toggles every cycle
  assign miso_w = spi_miso_oe_o ? spi_miso_o : ~miso_q;
  always @(posedge core_clk_i) miso_q <= miso_w;
  spi_unit spi_unit_inst (.core_clk_i, .reset_n_i, .clk_en_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .spi_clk_i, .spi_mosi_i, .slave_select_pin_n_i,
    .spi_miso_o, .spi_miso_oe_o, .baud_divisor_o, .divisor_valid_o,
    .tx_irq_o, .rx_irq_o, .irq_o);
  spi_master_model spi_master_model_inst (.sclk_o(spi_clk_i),
    .mosi_o(spi_mosi_i), .ss_n_o(slave_select_pin_n_i), .miso_i(miso_w));
  // ********************
  // helpers
  // ********************
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] s,
    input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // classic single cycle, held until ack, bounded wait
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    n = 0;
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge core_clk_i);
      n++;
    end
    chk("bus_ack", n < 20, 1'b1);
    if (n >= 20)
      report_and_stop;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [5:0] a,
    input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_reset;
    rc("rctl", ADDR_RECEIVE_CONTROL, RESET_ZERO);
    rc("ienable", ADDR_INTERRUPT_ENABLE_ONE, RESET_ZERO);
    rc("menable", ADDR_MODULE_ENABLE_TWO, RESET_ZERO);
    rc("flags", ADDR_IRQ_FLAGS, 8'h80);
    rc("unmapped", 6'h1E, 8'h00);
  endtask
  task automatic t_divisor;
    wr(ADDR_BAUD_DIVISOR_HIGH, 8'hA5);
    wr(ADDR_BAUD_DIVISOR_LOW, 8'h01);
    chk("divisor", baud_divisor_o, 16'hA501);
    wr(ADDR_BAUD_DIVISOR_HIGH, 8'h00);
    chk("div_valid", divisor_valid_o, 1'b0);
    wr(ADDR_BAUD_DIVISOR_LOW, 8'h02);
    chk("div_valid", divisor_valid_o, 1'b1);
    wr(ADDR_MODULATION_CONTROL, 8'h00);
    rc("modulation", ADDR_MODULATION_CONTROL, 8'h00);
  endtask
  // clock enable low: request waits and state stays frozen
  task automatic t_freeze;
    clk_en_i <= 1'b0;
    fork
      wr(ADDR_BAUD_DIVISOR_LOW, 8'h77);
      begin
        repeat (4) @(posedge core_clk_i);
        chk("frozen_ack", wb_ack_o, 1'b0);
        chk("frozen_div", baud_divisor_o, 16'h0002);
        clk_en_i <= 1'b1;
      end
    join
    chk("thawed_div", baud_divisor_o, 16'h0077);
  endtask
  // 8-bit, 4-pin: transmit char, flags, overrun and clear by read
  task automatic t_receive;
    logic [7:0] r;
    wr(ADDR_UNIT_CONTROL, 8'h10);
    wr(ADDR_TRANSMIT_BUFFER, 8'hC3);
    rc("flags", ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_MODULE_ENABLE_TWO, 8'h11);
    rc("menable", ADDR_MODULE_ENABLE_TWO, 8'h11);
    chk("miso_oe", spi_miso_oe_o, 1'b0);
    spi_master_model_inst.xfer(8'h5A, 8, r);
    chk("miso_char", r, 8'hC3);
    wr(ADDR_INTERRUPT_ENABLE_ONE, 8'h40);
    chk("rx_irq", rx_irq_o, 1'b1);
    chk("irq", irq_o, 1'b1);
    rc("rctl", ADDR_RECEIVE_CONTROL, 8'h80);
    spi_master_model_inst.xfer(8'h3C, 8, r);
    rc("rctl", ADDR_RECEIVE_CONTROL, 8'hA0);
    rc("rbuf", ADDR_RECEIVE_BUFFER, 8'h3C);
    rc("rctl", ADDR_RECEIVE_CONTROL, 8'h80);
    chk("rx_irq", rx_irq_o, 1'b0);
    wr(ADDR_INTERRUPT_ENABLE_ONE, 8'h80);
    chk("tx_irq", tx_irq_o, 1'b1);
    wr(ADDR_INTERRUPT_ENABLE_ONE, 8'h00);
  endtask
  // 7-bit, 3-pin: select ignored, alignment, reset bit
  task automatic t_seven;
    logic [7:0] r;
    wr(ADDR_RECEIVE_CONTROL, 8'h00);
    wr(ADDR_UNIT_CONTROL, 8'h02);
    chk("miso_oe", spi_miso_oe_o, 1'b1);
    wr(ADDR_TRANSMIT_BUFFER, 8'hB4);
    spi_master_model_inst.xfer(8'hFF, 7, r);
    chk("miso_seven", r, 8'hB4);
    spi_master_model_inst.xfer(8'hFF, 7, r);
    rc("rctl", ADDR_RECEIVE_CONTROL, 8'h20);
    rc("rbuf", ADDR_RECEIVE_BUFFER, 8'h7F);
    for (int k = 0; k < 2; k++)
      spi_master_model_inst.xfer(8'hFF, 7, r);
    rc("rctl", ADDR_RECEIVE_CONTROL, 8'h20);
    wr(ADDR_UNIT_CONTROL, 8'h03);
    rc("rctl", ADDR_RECEIVE_CONTROL, 8'h00);
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_divisor();
    t_freeze();
    t_receive();
    t_seven();
    report_and_stop();
  end
endmodule
